// ===== rtl/qio_cmd_top.sv
// Four-line protocol decoder for register and power instructions, with Wishbone register access
// Operation
// - Status read: opcode and byte on four lines
// - Register writes need write enable latch set
// - Status write: opcode and data on four
// - Write-disable bit set enters hardware protection
// - Protection exits only via extended protocol
// - Lock read: opcode, address, data on four
// - Lock write: opcode, address, data on four
// - Flag read returns flag status register
// - Flag clear resets four error flags
// - Flag clear needs no enable, keeps latch
// - Nonvolatile config read returns its register
// - Volatile config read returns its register
// - Fast power-on allows volatile writes unenabled
// - Write enable leaves fast power-on state
// - Deep sleep opcode enters deep power-down
// - Deep power-down ignores all but release
// - Release leaves deep power-down, decoding resumes
// - Write enable sets, disable clears latch
// - Chip select high returns to standby
`timescale 1ns/1ps
module qio_cmd_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Link pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o
);

	typedef struct packed {
		qio_cmd_pkg::phase_t phase; // Frame phase
		logic [7:0] op; // Opcode being received
		logic op_ok; // Opcode complete and accepted
		logic [2:0] cnt; // Nibble counter of current phase
		logic [7:0] b0; // First data byte
		logic [7:0] b1; // Second data byte
		logic first; // Next drive point loads the serialiser
		logic [7:0] sr; // Status register
		logic [7:0] flag; // Flag status register
		logic [15:0] nvcr; // Nonvolatile configuration
		logic [7:0] vcr; // Volatile configuration
		logic [7:0] vecr; // Enhanced volatile configuration
		logic [7:0] lock; // Lock bits
		logic write_enable_latch; // Write enable latch
		logic hardware_protected_mode; // Hardware protected mode
		logic fast_por; // Fast power-on state
		logic deep; // Deep power-down
		logic ext; // Extended protocol selected by software
		logic ack; // Wishbone acknowledge
		logic [31:0] rdat; // Wishbone read data
	} state_t;

	state_t q, d;
	link_if link ();
	logic out_load; // First drive point of a read
	logic out_shift; // Later drive points of a read
	logic out_drive; // Lines are ours
	logic [15:0] out_word; // Word offered to the serialiser
	logic wb_req; // Wishbone request pending
	logic [7:0] flag_set; // Error events from software
	logic [7:0] flag_next; // Flag register before clear handling

	// Read instructions whose answer follows the opcode or address
	function automatic logic is_read(input logic [7:0] op);
		is_read = (op == qio_cmd_pkg::STATUS_READ_CMD) || (op == qio_cmd_pkg::LOCK_READ_CMD) ||
			(op == qio_cmd_pkg::FLAG_STATUS_READ_CMD) || (op == qio_cmd_pkg::NONVOLATILE_CONFIG_READ_CMD) ||
			(op == qio_cmd_pkg::VOLATILE_CONFIG_READ_CMD) ||
			(op == qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_READ_CMD);
	endfunction

	// Write instructions that carry data
	function automatic logic is_write(input logic [7:0] op);
		is_write = (op == qio_cmd_pkg::STATUS_WRITE_CMD) || (op == qio_cmd_pkg::LOCK_WRITE_CMD) ||
			(op == qio_cmd_pkg::NONVOLATILE_CONFIG_WRITE_CMD) || (op == qio_cmd_pkg::VOLATILE_CONFIG_WRITE_CMD) ||
			(op == qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_WRITE_CMD);
	endfunction

	// Lock instructions carry an address before their data
	function automatic logic has_addr(input logic [7:0] op);
		has_addr = (op == qio_cmd_pkg::LOCK_READ_CMD) || (op == qio_cmd_pkg::LOCK_WRITE_CMD);
	endfunction

	// Volatile writes are the ones allowed in the fast power-on state
	function automatic logic is_volatile_write(input logic [7:0] op);
		is_volatile_write = (op == qio_cmd_pkg::VOLATILE_CONFIG_WRITE_CMD) ||
			(op == qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_WRITE_CMD);
	endfunction

	// Pin filter and edge finder
	link_sync sync_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cs_n_i(cs_n_i),
		.sclk_i(sclk_i),
		.io_i(io_i),
		.link(link)
	);

	// Word offered to the serialiser; byte registers repeat so a long read wraps on a byte
	always_comb begin
		case (q.op)
			qio_cmd_pkg::STATUS_READ_CMD: out_word = {q.sr, q.sr};
			qio_cmd_pkg::LOCK_READ_CMD: out_word = {q.lock, q.lock};
			qio_cmd_pkg::FLAG_STATUS_READ_CMD: out_word = {q.flag, q.flag};
			qio_cmd_pkg::NONVOLATILE_CONFIG_READ_CMD: out_word = {q.nvcr[7:0], q.nvcr[15:8]};
			qio_cmd_pkg::VOLATILE_CONFIG_READ_CMD: out_word = {q.vcr, q.vcr};
			qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_READ_CMD: out_word = {q.vecr, q.vecr};
			default: out_word = 16'h0000;
		endcase
	end

	// Serialiser strobes: drive on falling edges of the serial clock during the answer
	assign out_load = link.sclk_fall && (q.phase == qio_cmd_pkg::PH_DOUT) && q.first;
	assign out_shift = link.sclk_fall && (q.phase == qio_cmd_pkg::PH_DOUT) && !q.first;
	assign out_drive = (q.phase == qio_cmd_pkg::PH_DOUT) && !q.first && !link.cs_n;

	// Four-line serialiser
	nibble_out out_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(out_load),
		.shift_i(out_shift),
		.drive_i(out_drive),
		.word_i(out_word),
		.io_o(io_o),
		.io_oe_o(io_oe_o)
	);

	assign wb_req = wb_cyc_i && wb_stb_i;

	// Error events written by software; only the error bits can be raised this way
	assign flag_set = (wb_req && !q.ack && wb_we_i && wb_sel_i[0] && wb_adr_i == qio_cmd_pkg::FLAG_SET_OFS) ?
		(wb_dat_i[7:0] & qio_cmd_pkg::FLAG_ERROR_MASK) : 8'h00;
	assign flag_next = q.flag | flag_set;

	// Frame decoding, execution at frame end, and the Wishbone slave
	always_comb begin
		d = q;
		d.flag = flag_next;
		case (q.phase)
			// Standby: wait for selection
			qio_cmd_pkg::PH_IDLE: begin
				if (link.cs_fall && !q.ext) begin
					d.phase = qio_cmd_pkg::PH_OPCODE;
					d.cnt = 3'h0;
					d.op_ok = 1'b0;
					d.first = 1'b1;
				end
			end
			// Opcode arrives as two nibbles, high nibble first
			qio_cmd_pkg::PH_OPCODE: begin
				if (link.sclk_rise) begin
					d.op = {q.op[3:0], link.io_in};
					d.cnt = q.cnt + 3'h1;
					if (q.cnt + 3'h1 == qio_cmd_pkg::OP_NIBBLES) begin
						d.cnt = 3'h0;
						if (q.deep && d.op != qio_cmd_pkg::DEEP_SLEEP_RELEASE_CMD) begin
							d.phase = qio_cmd_pkg::PH_SKIP;
						end else if (has_addr(d.op)) begin
							d.op_ok = 1'b1;
							d.phase = qio_cmd_pkg::PH_ADDR;
						end else if (is_read(d.op)) begin
							d.op_ok = 1'b1;
							d.phase = qio_cmd_pkg::PH_DOUT;
						end else if (is_write(d.op)) begin
							d.op_ok = 1'b1;
							d.phase = qio_cmd_pkg::PH_DIN;
						end else begin
							d.op_ok = 1'b1;
							d.phase = qio_cmd_pkg::PH_SKIP;
						end
					end
				end
			end
			// Address nibbles; only the single lock byte exists, so the address is not kept
			qio_cmd_pkg::PH_ADDR: begin
				if (link.sclk_rise) begin
					d.cnt = q.cnt + 3'h1;
					if (q.cnt + 3'h1 == qio_cmd_pkg::ADDR_NIBBLES) begin
						d.cnt = 3'h0;
						d.phase = is_read(q.op) ? qio_cmd_pkg::PH_DOUT : qio_cmd_pkg::PH_DIN;
					end
				end
			end
			// Data nibbles; extra nibbles beyond the register width are dropped
			qio_cmd_pkg::PH_DIN: begin
				if (link.sclk_rise && q.cnt != qio_cmd_pkg::WORD_NIBBLES) begin
					d.cnt = q.cnt + 3'h1;
					case (q.cnt[1:0])
						2'h0: d.b0 = {link.io_in, q.b0[3:0]};
						2'h1: d.b0 = {q.b0[7:4], link.io_in};
						2'h2: d.b1 = {link.io_in, q.b1[3:0]};
						default: d.b1 = {q.b1[7:4], link.io_in};
					endcase
				end
			end
			// Answer phase: the serialiser is loaded on the first falling edge
			qio_cmd_pkg::PH_DOUT: begin
				if (out_load) begin
					d.first = 1'b0;
				end
			end
			// Ignored remainder of a frame
			qio_cmd_pkg::PH_SKIP: begin
				d.phase = qio_cmd_pkg::PH_SKIP;
			end
			default: begin
				d.phase = qio_cmd_pkg::PH_IDLE;
			end
		endcase

		// Frame end: execute, then stand by for the next selection
		if (link.cs_rise || (link.cs_n && q.phase != qio_cmd_pkg::PH_IDLE)) begin
			d.phase = qio_cmd_pkg::PH_IDLE;
			d.first = 1'b1;
			if (q.op_ok && link.cs_rise) begin
				case (q.op)
					qio_cmd_pkg::WRITE_ENABLE_CMD: begin
						d.write_enable_latch = 1'b1;
						d.fast_por = 1'b0;
					end
					qio_cmd_pkg::WRITE_DISABLE_CMD: begin
						d.write_enable_latch = 1'b0;
					end
					qio_cmd_pkg::FLAG_CLEAR_CMD: begin
						// Latch untouched; a same-cycle error event survives the clear
						d.flag = (q.flag & ~qio_cmd_pkg::FLAG_ERROR_MASK) | flag_set;
					end
					qio_cmd_pkg::DEEP_SLEEP_CMD: begin
						d.deep = 1'b1;
					end
					qio_cmd_pkg::DEEP_SLEEP_RELEASE_CMD: begin
						d.deep = 1'b0;
					end
					qio_cmd_pkg::STATUS_WRITE_CMD: begin
						// Protection blocks status writes until the extended protocol clears it
						if (q.write_enable_latch && !q.hardware_protected_mode && q.cnt >= qio_cmd_pkg::BYTE_NIBBLES) begin
							d.sr = q.b0;
							d.write_enable_latch = 1'b0;
							d.hardware_protected_mode = q.b0[qio_cmd_pkg::SR_WRITE_DISABLE_POS];
						end
					end
					qio_cmd_pkg::LOCK_WRITE_CMD: begin
						if (q.write_enable_latch && q.cnt >= qio_cmd_pkg::BYTE_NIBBLES) begin
							d.lock = q.b0;
							d.write_enable_latch = 1'b0;
						end
					end
					qio_cmd_pkg::NONVOLATILE_CONFIG_WRITE_CMD: begin
						// Least significant byte travels first
						if (q.write_enable_latch && q.cnt >= qio_cmd_pkg::WORD_NIBBLES) begin
							d.nvcr = {q.b1, q.b0};
							d.write_enable_latch = 1'b0;
						end
					end
					qio_cmd_pkg::VOLATILE_CONFIG_WRITE_CMD,
					qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_WRITE_CMD: begin
						if ((q.write_enable_latch || (q.fast_por && is_volatile_write(q.op))) &&
							q.cnt >= qio_cmd_pkg::BYTE_NIBBLES) begin
							if (q.op == qio_cmd_pkg::VOLATILE_CONFIG_WRITE_CMD) begin
								d.vcr = q.b0;
							end else begin
								d.vecr = q.b0;
							end
							d.write_enable_latch = 1'b0;
						end
					end
					default: begin
						d.op_ok = 1'b0;
					end
				endcase
			end
			d.op_ok = 1'b0;
		end

		// Leaving protection is only possible from the extended protocol
		if (q.ext) begin
			d.hardware_protected_mode = 1'b0;
			d.phase = qio_cmd_pkg::PH_IDLE;
		end

		// Wishbone: one-cycle acknowledge, registered one edge after the request
		d.ack = wb_req && !q.ack;
		d.rdat = 32'h00000000;
		if (wb_req && !q.ack) begin
			case (wb_adr_i)
				qio_cmd_pkg::CTRL_OFS: begin
					d.rdat = {30'h00000000, q.ext, q.fast_por};
					if (wb_we_i && wb_sel_i[0]) begin
						d.ext = wb_dat_i[qio_cmd_pkg::CTRL_EXTENDED_POS];
						// Software entering fast power-on wins over a same-cycle write enable
						if (wb_dat_i[qio_cmd_pkg::CTRL_FAST_POR_POS]) begin
							d.fast_por = 1'b1;
						end
					end
				end
				qio_cmd_pkg::STATE_OFS: begin
					d.rdat = {11'h000, q.ext, q.deep, q.fast_por, q.hardware_protected_mode, q.write_enable_latch, q.flag, q.sr};
				end
				qio_cmd_pkg::CONFIG_OFS: begin
					d.rdat = {q.vecr, q.vcr, q.nvcr};
				end
				qio_cmd_pkg::LOCK_OFS: begin
					d.rdat = {24'h000000, q.lock};
				end
				default: begin
					// Flag-set and unmapped offsets read zero and still acknowledge
					d.rdat = 32'h00000000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '{phase: qio_cmd_pkg::PH_IDLE, first: 1'b1, sr: qio_cmd_pkg::STATUS_RST,
				flag: qio_cmd_pkg::FLAG_RST, nvcr: qio_cmd_pkg::NVCR_RST, vcr: qio_cmd_pkg::VCR_RST,
				vecr: qio_cmd_pkg::VECR_RST, lock: qio_cmd_pkg::LOCK_RST, default: '0};
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;

endmodule

// ===== rtl/qio_cmd_pkg.sv
// Constants, opcodes, reset values and register map of the four-line command interpreter
package qio_cmd_pkg;

	// Instruction opcodes
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] LOCK_READ_CMD = 8'he8;
	localparam logic [7:0] LOCK_WRITE_CMD = 8'he5;
	localparam logic [7:0] FLAG_STATUS_READ_CMD = 8'h70;
	localparam logic [7:0] FLAG_CLEAR_CMD = 8'h50;
	localparam logic [7:0] NONVOLATILE_CONFIG_READ_CMD = 8'hb5;
	localparam logic [7:0] NONVOLATILE_CONFIG_WRITE_CMD = 8'hb1;
	localparam logic [7:0] VOLATILE_CONFIG_READ_CMD = 8'h85;
	localparam logic [7:0] VOLATILE_CONFIG_WRITE_CMD = 8'h81;
	localparam logic [7:0] ENHANCED_VOLATILE_CONFIG_READ_CMD = 8'h65;
	localparam logic [7:0] ENHANCED_VOLATILE_CONFIG_WRITE_CMD = 8'h61;
	localparam logic [7:0] DEEP_SLEEP_CMD = 8'hb9;
	localparam logic [7:0] DEEP_SLEEP_RELEASE_CMD = 8'hab;

	// Frame phases, one-hot
	typedef enum logic [5:0] {
		PH_IDLE = 6'h01,
		PH_OPCODE = 6'h02,
		PH_ADDR = 6'h04,
		PH_DIN = 6'h08,
		PH_DOUT = 6'h10,
		PH_SKIP = 6'h20
	} phase_t;

	// Nibble counts on the link
	localparam logic [2:0] OP_NIBBLES = 3'h2;
	localparam logic [2:0] ADDR_NIBBLES = 3'h6;
	localparam logic [2:0] BYTE_NIBBLES = 3'h2;
	localparam logic [2:0] WORD_NIBBLES = 3'h4;
	localparam logic [1:0] LAST_NIBBLE = 2'h3;

	// Field positions
	localparam int SR_WRITE_DISABLE_POS = 7;
	localparam logic [7:0] FLAG_ERROR_MASK = 8'h3a;

	// Values after reset
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h80;
	localparam logic [15:0] NVCR_RST = 16'hffff;
	localparam logic [7:0] VCR_RST = 8'hfb;
	localparam logic [7:0] VECR_RST = 8'hdf;
	localparam logic [7:0] LOCK_RST = 8'h00;

	// Wishbone register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATE_OFS = 8'h04;
	localparam logic [7:0] FLAG_SET_OFS = 8'h08;
	localparam logic [7:0] CONFIG_OFS = 8'h0c;
	localparam logic [7:0] LOCK_OFS = 8'h10;

	// Control register bits
	localparam int CTRL_FAST_POR_POS = 0;
	localparam int CTRL_EXTENDED_POS = 1;

	// Link input vector positions
	localparam int LINK_CS_POS = 5;
	localparam int LINK_SCLK_POS = 4;
	localparam logic [5:0] LINK_IDLE_LEVELS = 6'h20;

endpackage

// ===== rtl/link_if.sv
// Filtered link signals and edge events passed from the pin synchroniser to the decoder
`timescale 1ns/1ps
interface link_if;
	logic cs_n; // Filtered chip select, low active
	logic cs_fall; // One-cycle pulse: frame starts
	logic cs_rise; // One-cycle pulse: frame ends
	logic sclk_rise; // One-cycle pulse: sample point
	logic sclk_fall; // One-cycle pulse: drive point
	logic [3:0] io_in; // Filtered data lines

	modport src (output cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, io_in);
	modport dst (input cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, io_in);
endinterface

// ===== rtl/link_sync.sv
// Three-stage pin synchroniser with agreement filter and edge detection for the link pins
`timescale 1ns/1ps
module link_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] io_i,
	// Filtered link
	link_if.src link
);

	typedef struct packed {
		logic [5:0] s1; // First stage, read only by s2
		logic [5:0] s2;
		logic [5:0] s3;
		logic [5:0] lvl; // Accepted level
		logic cs_fall;
		logic cs_rise;
		logic sclk_rise;
		logic sclk_fall;
	} sync_t;

	sync_t q, d;

	// Accept a rise only once the second and third stages agree; a fall is taken as soon as they differ
	always_comb begin
		d = q;
		d.s1 = {cs_n_i, sclk_i, io_i};
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.lvl = (q.s2 & q.s3) | (q.lvl & ~(q.s2 ^ q.s3));
		d.cs_fall = q.lvl[qio_cmd_pkg::LINK_CS_POS] & ~d.lvl[qio_cmd_pkg::LINK_CS_POS];
		d.cs_rise = ~q.lvl[qio_cmd_pkg::LINK_CS_POS] & d.lvl[qio_cmd_pkg::LINK_CS_POS];
		d.sclk_rise = ~q.lvl[qio_cmd_pkg::LINK_SCLK_POS] & d.lvl[qio_cmd_pkg::LINK_SCLK_POS];
		d.sclk_fall = q.lvl[qio_cmd_pkg::LINK_SCLK_POS] & ~d.lvl[qio_cmd_pkg::LINK_SCLK_POS];
	end

	// State register; reset assumes a deselected bus
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '{s1: qio_cmd_pkg::LINK_IDLE_LEVELS, s2: qio_cmd_pkg::LINK_IDLE_LEVELS,
				s3: qio_cmd_pkg::LINK_IDLE_LEVELS, lvl: qio_cmd_pkg::LINK_IDLE_LEVELS, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Data lines carry the same latency as the clock, so a sampled nibble matches its edge
	assign link.cs_n = q.lvl[qio_cmd_pkg::LINK_CS_POS];
	assign link.cs_fall = q.cs_fall;
	assign link.cs_rise = q.cs_rise;
	assign link.sclk_rise = q.sclk_rise;
	assign link.sclk_fall = q.sclk_fall;
	assign link.io_in = q.lvl[3:0];

endmodule

// ===== rtl/nibble_out.sv
// Nibble serialiser driving four data lines from a 16-bit word, most significant nibble first
`timescale 1ns/1ps
module nibble_out (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control from the decoder
	input wire logic load_i,
	input wire logic shift_i,
	input wire logic drive_i,
	input wire logic [15:0] word_i,
	// Data lines
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o
);

	typedef struct packed {
		logic [15:0] word; // Word being sent
		logic [1:0] idx; // Nibble on the lines
		logic [3:0] nib;
		logic [3:0] oe;
	} out_t;

	out_t q, d;

	// Pick nibble n counted from the top
	function automatic logic [3:0] pick(input logic [15:0] w, input logic [1:0] n);
		pick = w[(4'hc - {n, 2'b00}) +: 4];
	endfunction

	// Reload the live word at each wrap, so a register read repeats with fresh contents
	always_comb begin
		d = q;
		d.oe = {4{drive_i}};
		if (load_i || (shift_i && q.idx == qio_cmd_pkg::LAST_NIBBLE)) begin
			d.word = word_i;
			d.idx = 2'h0;
			d.nib = pick(word_i, 2'h0);
		end else if (shift_i) begin
			d.idx = q.idx + 2'h1;
			d.nib = pick(q.word, q.idx + 2'h1);
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign io_o = q.nib;
	assign io_oe_o = q.oe;

endmodule

// ===== bench/qio_cmd_checker.sv
// Port-level assertions for the four-line command decoder
`timescale 1ns/1ps
module qio_cmd_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Link
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] io_o,
	input wire logic [3:0] io_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A request the slave has not answered yet
	logic req;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	a_oe_all_lanes: assert property (io_oe_o == 4'h0 || io_oe_o == 4'hf) else $error("lanes enabled apart");
	a_quiet_deselect: assert property (cs_n_i [*8] |-> io_oe_o == 4'h0) else $error("driving while deselected");
	a_quiet_opcode: assert property ($fell(cs_n_i) |=> (io_oe_o == 4'h0) [*8]) else $error("driving in opcode");
	a_load_clk_low: assert property ($rose(io_oe_o[0]) |-> !cs_n_i && !sclk_i) else $error("drive start misplaced");
	a_shift_on_fall: assert property (io_oe_o[0] && $past(io_oe_o[0]) && io_o != $past(io_o) |-> !sclk_i)
		else $error("nibble changed with clock high");
	a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_has_req: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	a_dat_unmapped: assert property (req && (wb_adr_i == 8'h08 || wb_adr_i > 8'h10) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	// Main scenarios reached
	c_read_out: cover property ($rose(io_oe_o[0]));
	c_frame: cover property ($fell(cs_n_i));
	c_bus: cover property (req ##1 wb_ack_o);
endmodule
bind qio_cmd_top qio_cmd_checker i_qio_cmd_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cs_n_i(cs_n_i),
	.sclk_i(sclk_i), .io_o(io_o), .io_oe_o(io_oe_o));

// ===== bench/qio_host_model.sv
// Host controller model driving frames on the four-line link
`timescale 1ns/1ps
module qio_host_model (
	// Clock
	input wire logic clk_i,
	// Link pins
	output logic cs_n_o,
	output logic sclk_o,
	output logic [3:0] io_o,
	input wire logic [3:0] io_i
);
	// Idle: deselected, serial clock parked low
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		io_o = 4'h5;
	end
	// Half a serial clock period: 8 system cycles, so 160 ns a period
	task automatic half();
		repeat (8) @(posedge clk_i);
	endtask
	// Drive a nibble with clock low, device samples at the rise
	task automatic put(input logic [3:0] v);
		io_o <= v;
		half();
		sclk_o <= 1'b1;
		half();
		sclk_o <= 1'b0;
	endtask
	// Opcode, n input nibbles (high first), then nout answer nibbles
	task automatic frame(input logic [7:0] op, input int n, input logic [31:0] din, input int nout,
		output logic [15:0] dout);
		dout = 16'h0;
		cs_n_o <= 1'b0;
		half();
		put(op[7:4]);
		put(op[3:0]);
		for (int i = n - 1; i >= 0; i--) put(din[4*i +: 4]);
		// Released lines show the inverse so stale data never passes for an answer
		io_o <= ~io_o;
		for (int i = 0; i < nout; i++) begin
			half();
			sclk_o <= 1'b1;
			dout = {dout[11:0], io_i};
			half();
			sclk_o <= 1'b0;
		end
		half();
		cs_n_o <= 1'b1;
		io_o <= ~io_o;
		repeat (16) @(posedge clk_i);
	endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the four-line command decoder
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	// Clock, reset and bus master
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] dat_o, q, d;
	logic ack;
	// Link: device wins the wire only while enabled
	logic cs_n, sclk;
	logic [3:0] h_io, d_io, d_oe;
	wire logic [3:0] pin = (d_oe != 4'h0) ? d_io : h_io;
	// Expected device state
	logic [7:0] sr, fl, vcr, vecr, lk;
	logic [15:0] nv;
	logic write_enable_latch, hardware_protected_mode, fp, dp, ex;
	int fails = 0;
	int num_checks = 0;
	int seed;
	qio_cmd_top i_qio_cmd_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.cs_n_i(cs_n), .sclk_i(sclk), .io_i(pin), .io_o(d_io), .io_oe_o(d_oe));
	qio_host_model i_qio_host_model (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(h_io), .io_i(pin));
	initial begin
		forever #5 clk = ~clk;
	end
	// Expected status word from the model state
	function automatic logic [31:0] state_word();
		return {11'h0, ex, dp, fp, hardware_protected_mode, write_enable_latch, fl, sr};
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One classic cycle; waits for ack under a bound
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= v;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		r = dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		if (n >= 50) begin
			fails++;
			tally_and_finish();
		end
		@(posedge clk);
	endtask
	task automatic chk_state();
		wb(1'b0, qio_cmd_pkg::STATE_OFS, 32'h0, q);
		`CHK(q, state_word())
	endtask
	task automatic link_wr(input logic [7:0] op, input int n, input logic [31:0] v);
		logic [15:0] r;
		i_qio_host_model.frame(op, n, v, 0, r);
	endtask
	task automatic link_rd(input logic [7:0] op, input int na, input int n, input logic [15:0] e);
		logic [15:0] r;
		i_qio_host_model.frame(op, na, 32'h0, n, r);
		`CHK(r, e)
	endtask
	initial begin
		seed = 32'h576fb238;
		{sr, fl, vcr, vecr, nv, lk} = {qio_cmd_pkg::STATUS_RST, qio_cmd_pkg::FLAG_RST, qio_cmd_pkg::VCR_RST,
			qio_cmd_pkg::VECR_RST, qio_cmd_pkg::NVCR_RST, qio_cmd_pkg::LOCK_RST};
		{write_enable_latch, hardware_protected_mode, fp, dp, ex} = 5'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		// Reset values, write-only and unmapped words
		chk_state();
		wb(1'b0, qio_cmd_pkg::CONFIG_OFS, 32'h0, q);
		`CHK(q, {vecr, vcr, nv})
		// Control, flag-set, lock and one unmapped word all read zero after reset
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(32'h14100800 >> (8 * i)), 32'h0, q);
			`CHK(q, 32'h0)
		end
		// Fast power-on: volatile writes need no enable
		wb(1'b1, qio_cmd_pkg::CTRL_OFS, 32'h1, q);
		fp = 1'b1;
		d = $random(seed);
		link_wr(qio_cmd_pkg::VOLATILE_CONFIG_WRITE_CMD, 2, {24'h0, d[7:0]});
		link_wr(qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_WRITE_CMD, 2, {24'h0, d[15:8]});
		{vecr, vcr} = d[15:0];
		link_rd(qio_cmd_pkg::VOLATILE_CONFIG_READ_CMD, 0, 2, {8'h0, vcr});
		link_rd(qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_READ_CMD, 0, 2, {8'h0, vecr});
		chk_state();
		link_wr(qio_cmd_pkg::WRITE_ENABLE_CMD, 0, 32'h0);
		{write_enable_latch, fp} = 2'b10;
		chk_state();
		link_wr(qio_cmd_pkg::WRITE_DISABLE_CMD, 0, 32'h0);
		write_enable_latch = 1'b0;
		chk_state();
		// Every register write, enabled then unenabled, read back on the link
		for (int en = 1; en >= 0; en--) begin
			for (int k = 0; k < 5; k++) begin
				d = $random(seed);
				d[7] = 1'b0;
				if (en == 1) link_wr(qio_cmd_pkg::WRITE_ENABLE_CMD, 0, 32'h0);
				case (k)
					0: link_wr(qio_cmd_pkg::STATUS_WRITE_CMD, 2, {24'h0, d[7:0]});
					1: link_wr(qio_cmd_pkg::LOCK_WRITE_CMD, 8, d);
					2: link_wr(qio_cmd_pkg::NONVOLATILE_CONFIG_WRITE_CMD, 4, {16'h0, d[7:0], d[15:8]});
					3: link_wr(qio_cmd_pkg::VOLATILE_CONFIG_WRITE_CMD, 2, {24'h0, d[7:0]});
					default: link_wr(qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_WRITE_CMD, 2, {24'h0, d[7:0]});
				endcase
				if (en == 1) begin
					case (k)
						0: sr = d[7:0];
						1: lk = d[7:0];
						2: nv = d[15:0];
						3: vcr = d[7:0];
						default: vecr = d[7:0];
					endcase
				end
				link_rd(qio_cmd_pkg::STATUS_READ_CMD, 0, 2, {8'h0, sr});
				link_rd(qio_cmd_pkg::LOCK_READ_CMD, 6, 2, {8'h0, lk});
				link_rd(qio_cmd_pkg::NONVOLATILE_CONFIG_READ_CMD, 0, 4, {nv[7:0], nv[15:8]});
				link_rd(qio_cmd_pkg::VOLATILE_CONFIG_READ_CMD, 0, 2, {8'h0, vcr});
				link_rd(qio_cmd_pkg::ENHANCED_VOLATILE_CONFIG_READ_CMD, 0, 2, {8'h0, vecr});
				chk_state();
			end
		end
		// Error flags: set over the bus, read, clear with and without the latch
		for (int k = 0; k < 2; k++) begin
			wb(1'b1, qio_cmd_pkg::FLAG_SET_OFS, 32'hff, q);
			fl = qio_cmd_pkg::FLAG_RST | qio_cmd_pkg::FLAG_ERROR_MASK;
			link_rd(qio_cmd_pkg::FLAG_STATUS_READ_CMD, 0, 2, {8'h0, fl});
			link_wr(k == 0 ? qio_cmd_pkg::WRITE_ENABLE_CMD : qio_cmd_pkg::WRITE_DISABLE_CMD, 0, 32'h0);
			write_enable_latch = (k == 0);
			link_wr(qio_cmd_pkg::FLAG_CLEAR_CMD, 0, 32'h0);
			fl = qio_cmd_pkg::FLAG_RST;
			chk_state();
		end
		// Write-disable bit enters protection; only the extended switch leaves it
		link_wr(qio_cmd_pkg::WRITE_ENABLE_CMD, 0, 32'h0);
		link_wr(qio_cmd_pkg::STATUS_WRITE_CMD, 2, 32'h80);
		{sr, hardware_protected_mode, write_enable_latch} = {8'h80, 2'b10};
		chk_state();
		link_wr(qio_cmd_pkg::WRITE_ENABLE_CMD, 0, 32'h0);
		link_wr(qio_cmd_pkg::STATUS_WRITE_CMD, 2, 32'h00);
		write_enable_latch = 1'b1;
		chk_state();
		wb(1'b1, qio_cmd_pkg::CTRL_OFS, 32'h2, q);
		{hardware_protected_mode, ex} = 2'b01;
		chk_state();
		wb(1'b1, qio_cmd_pkg::CTRL_OFS, 32'h0, q);
		ex = 1'b0;
		// Deep power-down ignores all but release
		link_wr(qio_cmd_pkg::WRITE_DISABLE_CMD, 0, 32'h0);
		link_wr(qio_cmd_pkg::DEEP_SLEEP_CMD, 0, 32'h0);
		{write_enable_latch, dp} = 2'b01;
		chk_state();
		link_wr(qio_cmd_pkg::WRITE_ENABLE_CMD, 0, 32'h0);
		chk_state();
		link_wr(qio_cmd_pkg::DEEP_SLEEP_RELEASE_CMD, 0, 32'h0);
		link_wr(qio_cmd_pkg::WRITE_ENABLE_CMD, 0, 32'h0);
		{write_enable_latch, dp} = 2'b10;
		chk_state();
		// A frame cut short is dropped and the next decodes normally
		link_wr(qio_cmd_pkg::VOLATILE_CONFIG_WRITE_CMD, 1, 32'h3);
		link_rd(qio_cmd_pkg::VOLATILE_CONFIG_READ_CMD, 0, 2, {8'h0, vcr});
		chk_state();
		tally_and_finish();
	end
endmodule
